// File: include/adc_port_pkg.sv
/*
 * shared constants and carrier types for the sampling converter output port.
 * assumes a single 50 MHz system clock that stands in for the sample clock.
 */
package adc_port_pkg;
	localparam int unsigned code_width = 8;
	localparam int unsigned pipe_depth = 5;
	localparam int unsigned clk_period_ns = 20;
	localparam int unsigned wake_time_ns = 1000;
	// longest wait rounds down
	localparam int unsigned wake_cycles = wake_time_ns / clk_period_ns;
	localparam int unsigned wake_cnt_width = $clog2(wake_cycles + 1);
	localparam logic [code_width-1:0] code_zero = 8'h00;
	localparam logic [code_width-1:0] code_full = 8'hff;

	// one analog sample as the front end presents it
	typedef struct packed {
		logic below_bottom;
		logic above_top;
		logic [code_width-1:0] level;
	} sample_t;

	typedef enum logic [1:0] {
		st_active = 2'b00,
		st_sleep = 2'b01,
		st_wake = 2'b11
	} power_state_t;
endpackage : adc_port_pkg

// File: verilog/adc_output_port.sv
/*
 * digital back end of an 8-bit pipelined sampling converter: range clamp,
 * five-stage latency pipeline, output register and sleep control.
 * assumes the analog front end delivers a quantized level plus out-of-range
 * flags each cycle, and that a stopped sample clock simply stops clk_sys_in.
 */
`timescale 1ns/1ns

module adc_output_port #(
	parameter int unsigned width = adc_port_pkg::code_width,
	parameter int unsigned depth = adc_port_pkg::pipe_depth
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// analog front end and control pin
	input wire adc_port_pkg::sample_t sample_in,
	input wire logic sleep_request_in,
	// parallel output
	output logic [width-1:0] code_out,
	output logic data_valid_out,
	output logic low_power_out
);
	logic sleep_meta_r;
	logic sleep_sync_r;
	logic [width-1:0] stage_r [depth];
	logic [width-1:0] code_r;
	logic valid_r;
	logic low_power_r;
	adc_port_pkg::power_state_t state_r;
	adc_port_pkg::power_state_t state_nxt;
	logic [adc_port_pkg::wake_cnt_width-1:0] wake_cnt_r;
	logic [adc_port_pkg::wake_cnt_width-1:0] wake_cnt_nxt;
	logic [width-1:0] clamped;
	wire converting;
	wire wake_done;

	// saturate out-of-range samples, keep straight binary otherwise
	assign clamped = sample_in.below_bottom ? width'(adc_port_pkg::code_zero) :
		sample_in.above_top ? width'(adc_port_pkg::code_full) :
		sample_in.level;
	assign converting = (state_r != adc_port_pkg::st_sleep);
	assign wake_done = (wake_cnt_r == adc_port_pkg::wake_cnt_width'(adc_port_pkg::wake_cycles));

	// sleep pin is asynchronous to the sample clock
	always_ff @(posedge clk_sys_in) begin
		sleep_meta_r <= sleep_request_in;
		sleep_sync_r <= sleep_meta_r;
	end

	always_comb begin
		state_nxt = state_r;
		wake_cnt_nxt = wake_cnt_r;
		unique case (state_r)
			adc_port_pkg::st_active: begin
				if (sleep_sync_r) begin
					state_nxt = adc_port_pkg::st_sleep;
				end
			end
			adc_port_pkg::st_sleep: begin
				wake_cnt_nxt = '0;
				if (!sleep_sync_r) begin
					state_nxt = adc_port_pkg::st_wake;
				end
			end
			adc_port_pkg::st_wake: begin
				wake_cnt_nxt = wake_cnt_r + 1'b1;
				if (sleep_sync_r) begin
					state_nxt = adc_port_pkg::st_sleep;
				end else if (wake_done) begin
					state_nxt = adc_port_pkg::st_active;
				end
			end
			default: begin
				state_nxt = adc_port_pkg::st_active;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state_r <= adc_port_pkg::st_active;
			wake_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
		end
	end

	// latency pipeline: stage 0 captures, each stage advances every edge outside sleep
	generate
		for (genvar i = 0; i < depth; i++) begin : g_stage
			always_ff @(posedge clk_sys_in) begin
				if (converting) begin
					stage_r[i] <= (i == 0) ? clamped : stage_r[(i == 0) ? 0 : i - 1];
				end
			end
		end
	endgenerate

	// output word is the sample captured depth edges earlier; frozen in sleep
	always_ff @(posedge clk_sys_in) begin
		if (converting) begin
			code_r <= stage_r[depth-1];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			valid_r <= 1'b0;
			low_power_r <= 1'b0;
		end else begin
			valid_r <= (state_nxt == adc_port_pkg::st_active);
			low_power_r <= (state_nxt == adc_port_pkg::st_sleep);
		end
	end

	assign code_out = code_r;
	assign data_valid_out = valid_r;
	assign low_power_out = low_power_r;

	// checks: what the pipeline was fed, one entry per edge
	logic [width-1:0] clamp_hist [depth];
	logic [depth-1:0] conv_hist;
	// edges since the bus left sleep with the pin still low
	logic [adc_port_pkg::wake_cnt_width:0] awake_cnt_r;
	logic from_sleep_r;
	wire awake_early;
	wire awake_due;

	// last edge that must still read invalid, then the first that must read valid
	assign awake_early = from_sleep_r &&
		(awake_cnt_r == (adc_port_pkg::wake_cnt_width + 1)'(adc_port_pkg::wake_cycles));
	assign awake_due = from_sleep_r &&
		(awake_cnt_r == (adc_port_pkg::wake_cnt_width + 1)'(adc_port_pkg::wake_cycles + 1));

	// saturates so a long active spell never wraps back onto the checked counts
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			from_sleep_r <= 1'b0;
			awake_cnt_r <= '0;
		end else if (low_power_r || sleep_sync_r) begin
			from_sleep_r <= low_power_r;
			awake_cnt_r <= '0;
		end else if (!(&awake_cnt_r)) begin
			awake_cnt_r <= awake_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		clamp_hist[0] <= clamped;
		conv_hist[0] <= converting;
		for (int k = 1; k < depth; k++) begin
			clamp_hist[k] <= clamp_hist[k-1];
			conv_hist[k] <= conv_hist[k-1];
		end
	end

	property p_latency;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		((&conv_hist) && $past(conv_hist[depth-1])) |-> (code_r == $past(clamp_hist[depth-1]));
	endproperty
	a_latency: assert property (p_latency) else $error("code not five cycles after sample");

	property p_low_clamp;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		sample_in.below_bottom |-> (clamped == '0);
	endproperty
	a_low_clamp: assert property (p_low_clamp) else $error("below range not zero");

	property p_high_clamp;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(sample_in.above_top && !sample_in.below_bottom) |-> (&clamped);
	endproperty
	a_high_clamp: assert property (p_high_clamp) else $error("above range not all ones");

	property p_in_range;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(!sample_in.above_top && !sample_in.below_bottom) |-> (clamped == sample_in.level);
	endproperty
	a_in_range: assert property (p_in_range) else $error("in-range code altered");

	property p_sleep_hold;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(low_power_r && $past(low_power_r)) |-> $stable(code_r);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("bus moved in sleep");

	sequence s_pin_rise;
		$rose(sleep_request_in) ##1 sleep_request_in[*3];
	endsequence
	property p_enter_sleep;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		s_pin_rise |-> low_power_r;
	endproperty
	a_enter_sleep: assert property (p_enter_sleep) else $error("sleep not entered");

	sequence s_wake_start;
		$fell(low_power_r) && !sleep_sync_r;
	endsequence
	property p_wake_delay;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		s_wake_start ##0 (!sleep_sync_r)[*8] |-> !data_valid_out;
	endproperty
	a_wake_delay: assert property (p_wake_delay) else $error("valid too soon after wake");

	property p_active_valid;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		awake_due |-> data_valid_out;
	endproperty
	a_active_valid: assert property (p_active_valid) else $error("valid missing after wake");

	// wake interval seen from the bus
	property p_wake_not_early;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		awake_early |-> !data_valid_out;
	endproperty
	a_wake_not_early: assert property (p_wake_not_early) else $error("valid before wake interval");

	property p_wake_from_low;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		$fell(low_power_r) |-> !data_valid_out;
	endproperty
	a_wake_from_low: assert property (p_wake_from_low) else $error("valid at end of sleep");

	property p_wake_interrupt;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(!low_power_r && !data_valid_out && sleep_sync_r) |=> !data_valid_out;
	endproperty
	a_wake_interrupt: assert property (p_wake_interrupt) else $error("valid despite sleep in wake");

	// sleep entry and exit follow the synchronised pin only
	property p_sync_sleep;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		sleep_sync_r |=> low_power_r;
	endproperty
	a_sync_sleep: assert property (p_sync_sleep) else $error("sleep request ignored");

	property p_sleep_keeps;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(low_power_r && sleep_sync_r) |=> (low_power_r && !data_valid_out);
	endproperty
	a_sleep_keeps: assert property (p_sleep_keeps) else $error("sleep left while pin high");

	property p_lp_from_pin;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		$rose(low_power_r) |-> $past(sleep_sync_r);
	endproperty
	a_lp_from_pin: assert property (p_lp_from_pin) else $error("sleep without request");

	property p_valid_excl;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		low_power_r |-> !data_valid_out;
	endproperty
	a_valid_excl: assert property (p_valid_excl) else $error("valid during sleep");

	property p_stay_active;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(data_valid_out && !sleep_sync_r) |=> data_valid_out;
	endproperty
	a_stay_active: assert property (p_stay_active) else $error("active state dropped");

	property p_valid_needs_pin;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		$rose(data_valid_out) |-> !$past(sleep_sync_r);
	endproperty
	a_valid_needs_pin: assert property (p_valid_needs_pin) else $error("valid with pin high");

	property p_clamp_priority;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(sample_in.below_bottom && sample_in.above_top) |-> (clamped == width'(adc_port_pkg::code_zero));
	endproperty
	a_clamp_priority: assert property (p_clamp_priority) else $error("low clamp lost priority");

	// every stage freezes in sleep; otherwise stage 0 takes the clamped sample and each later stage its neighbour's word
	generate
		for (genvar i = 0; i < depth; i++) begin : g_stage_chk
			property p_stage_hold;
				@(posedge clk_sys_in) disable iff (!rst_b_in)
				(low_power_r && $past(low_power_r)) |-> $stable(stage_r[i]);
			endproperty
			a_stage_hold: assert property (p_stage_hold) else $error("stage moved in sleep");

			property p_stage_step;
				@(posedge clk_sys_in) disable iff (!rst_b_in)
				((&conv_hist) && $past(conv_hist[depth-1])) |->
					(stage_r[i] == ((i == 0) ? $past(clamped) : $past(stage_r[(i == 0) ? 0 : i - 1])));
			endproperty
			a_stage_step: assert property (p_stage_step) else $error("stage skipped a word");
		end
	endgenerate
endmodule : adc_output_port

// File: tb/host_capture.sv
/* host model: counts the words it accepts.
 assumes the port's own clock. */
`timescale 1ns/1ns
module host_capture (
	// port side
	input wire logic clk_in,
	input wire logic valid_in,
	// tally
	output int n_words_out
);
	initial n_words_out = 0;
	// words before valid are discarded
	always @(posedge clk_in) begin
		if (valid_in) n_words_out <= n_words_out + 1;
	end
endmodule : host_capture

// File: tb/tb.sv
/* self-checking bench for the output port.
 assumes host_capture beside the port. */
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic run = 1'b1;
	logic rst_b = 1'b0;
	logic slp = 1'b0;
	adc_port_pkg::sample_t smp = '0;
	logic [7:0] code;
	logic vld;
	logic lp;
	int n_words;
	int n_fail = 0;
	int tests_run = 0;
	logic [7:0] eq[$];
	wire dclk = clk & run;
	always #10 clk = ~clk;
	adc_output_port u_adc_output_port (.clk_sys_in(dclk), .rst_b_in(rst_b), .sample_in(smp),
		.sleep_request_in(slp), .code_out(code), .data_valid_out(vld), .low_power_out(lp));
	host_capture u_host_capture (.clk_in(dclk), .valid_in(vld), .n_words_out(n_words));
	task summarize;
		$display("checks %0d errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// back-to-back samples, clamps mixed in
	task t_stream(input int n);
		eq.delete();
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			smp.level = 8'(i * 37);
			smp.below_bottom = (i % 5 == 2);
			smp.above_top = (i % 4 == 3);
			eq.push_back(smp.below_bottom ? adc_port_pkg::code_zero :
				smp.above_top ? adc_port_pkg::code_full : smp.level);
			chk({7'h00, vld}, 8'h01, "valid");
			if (eq.size() > 6) chk(code, eq[eq.size()-7], "code");
		end
	endtask : t_stream
	task t_stop;
		logic [7:0] held;
		@(negedge clk);
		run = 1'b0;
		held = code;
		repeat (8) begin
			@(negedge clk);
			smp.level = smp.level + 8'h11;
			chk(code, held, "stopped");
		end
		run = 1'b1;
	endtask : t_stop
	task t_sleep;
		logic [7:0] held;
		int k;
		k = 0;
		@(negedge clk);
		slp = 1'b1;
		while (lp !== 1'b1 && k < 10) begin
			@(negedge clk);
			k++;
		end
		held = code;
		repeat (8) begin
			@(negedge clk);
			smp.level = smp.level + 8'h05;
			chk(code, held, "sleep hold");
			chk({lp, vld}, 8'h02, "sleep flags");
		end
		run = 1'b0;
		repeat (4) @(negedge clk);
		chk(code, held, "sleep stopped");
		run = 1'b1;
		slp = 1'b0;
		k = 0;
		while (vld !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		chk(8'(k >= adc_port_pkg::wake_cycles && k <= adc_port_pkg::wake_cycles + 4), 8'h01, "wake");
		chk({7'h00, lp}, 8'h00, "awake");
	endtask : t_sleep
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		t_stream(24);
		t_stop;
		t_stream(12);
		t_sleep;
		t_stream(12);
		chk(8'(n_words > 40), 8'h01, "host");
		summarize;
	end
	initial begin
		#20000;
		n_fail++;
		summarize;
	end
endmodule : tb
